//--- logic/sfc_pkg.sv
// package for the stream formatter control register bank
package sfc_pkg;
   // register byte addresses
   localparam logic [7:0] SFC_MPEG_CTRL_ADDR = 8'hf0;
   localparam logic [7:0] SFC_DSS_CTRL_ADDR = 8'hf4;
   localparam logic [31:0] SFC_CTRL_RESET = 32'h0000_0000;
   // field positions
   localparam int SFC_RX_ENABLE_BIT = 0;
   localparam int SFC_TX_ENABLE_BIT = 1;
   localparam int SFC_TX_ERR_MODE_BIT = 4;
   localparam int SFC_RX_ERR_MODE_BIT = 5;
   localparam int SFC_TX_AGING_BIT = 6;
   localparam int SFC_RX_AGING_BIT = 7;
   localparam int SFC_CLASS_LSB = 13;
   localparam int SFC_CLASS_MSB = 15;
   localparam int SFC_HDR_STRIP_BIT = 16;
   localparam int SFC_EXT_TS_BIT = 17;
   localparam int SFC_RX130_BIT = 22;
   localparam int SFC_TX130_BIT = 23;
   localparam int SFC_RX_DEST_BIT = 24;
   localparam int SFC_TX_SRC_BIT = 25;
   localparam int SFC_RX_FLUSH_BIT = 26;
   localparam int SFC_TX_FLUSH_BIT = 27;
   localparam int SFC_MODE_BIT = 28;
   localparam int SFC_TS_INSERT_BIT = 29;
   localparam int SFC_ALT_CELL_BIT = 30;
   localparam int SFC_HDR_INSERT_BIT = 31;
   // writable bits (reserved 2-3, 8-12, 18-21 and self-clearing flushes read zero)
   localparam logic [31:0] SFC_RW_MASK = 32'hf3c3_e0f3;

   // transmit packing classes
   typedef enum logic [2:0] {
      SFC_CLASS_DIV8 = 3'b000,
      SFC_CLASS_DIV4 = 3'b001,
      SFC_CLASS_DIV2 = 3'b010,
      SFC_CLASS_ONE = 3'b011,
      SFC_CLASS_UPTO2 = 3'b100,
      SFC_CLASS_UPTO3 = 3'b101,
      SFC_CLASS_UPTO4 = 3'b110,
      SFC_CLASS_UPTO5 = 3'b111
   } sfc_class_type;

   // decoded controls of one formatter, shared layout for both
   typedef struct packed {
      logic rx_enable;
      logic tx_enable;
      logic tx_aging_enable;
      logic rx_aging_enable;
      sfc_class_type tx_packing_class;
      logic header_strip;
      logic extended_timestamp;
      logic rx_format130_ready;
      logic tx_format130_ready;
      logic rx_to_port;
      logic tx_from_port;
      logic rx_fifo_flush;
      logic tx_fifo_flush;
      logic stream_mode_select;
      logic tx_timestamp_insert;
      logic alternate_cell_size_enable;
      logic tx_header_insert;
   } sfc_ctrl_type;
endpackage : sfc_pkg

//--- logic/sfc_regs.sv
// stream formatter control registers (mpeg and dss) behind an apb slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sfc_regs
   import sfc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // decoded controls to the formatters
   output sfc_ctrl_type mpeg_ctrl,
   output sfc_ctrl_type dss_ctrl,
   // error signal mapping on the application port (pins, synchronised here)
   input wire logic port_tx_error_in,
   input wire logic rx_status_bit,
   output logic tx_error_status_bit,
   output logic port_rx_error_out
);
   logic [31:0] mpeg_q, dss_q;
   logic [1:0] txerr_sync_q, rxstat_sync_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic tx_err_q, rx_err_q;
   // decoded field flops, one set per formatter
   logic mpeg_rx_en_q, mpeg_tx_en_q, dss_rx_en_q, dss_tx_en_q;
   logic mpeg_tx_age_q, mpeg_rx_age_q, dss_tx_age_q, dss_rx_age_q;
   sfc_class_type mpeg_class_q, dss_class_q;
   logic mpeg_hdr_strip_q, mpeg_ext_ts_q, dss_hdr_strip_q, dss_ext_ts_q;
   logic mpeg_rx130_q, mpeg_tx130_q, dss_rx130_q, dss_tx130_q;
   logic mpeg_rx_port_q, mpeg_tx_port_q, dss_rx_port_q, dss_tx_port_q;
   logic mpeg_rx_flush_q, mpeg_tx_flush_q, dss_rx_flush_q, dss_tx_flush_q;
   logic mpeg_mode_q, dss_mode_q;
   logic mpeg_ts_ins_q, dss_ts_ins_q;
   logic mpeg_alt_cell_q, dss_alt_cell_q;
   logic mpeg_hdr_ins_q, dss_hdr_ins_q;

   wire logic wr_acc = psel & penable & pwrite;
   wire logic rd_acc = psel & penable & ~pwrite;
   wire logic hit_mpeg = (paddr == SFC_MPEG_CTRL_ADDR);
   wire logic hit_dss = (paddr == SFC_DSS_CTRL_ADDR);

   // byte-lane merge of a write into a control word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // stored words hold only writable bits; flush bits are never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_q <= SFC_CTRL_RESET;
         dss_q <= SFC_CTRL_RESET;
      end else if (wr_acc) begin
         if (hit_mpeg) begin
            mpeg_q <= merge(mpeg_q, pwdata, pstrb) & SFC_RW_MASK;
         end
         if (hit_dss) begin
            dss_q <= merge(dss_q, pwdata, pstrb) & SFC_RW_MASK;
         end
      end
   end

   // fifo enables; decoded one edge after the word is stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_rx_en_q <= 1'b0;
         mpeg_tx_en_q <= 1'b0;
         dss_rx_en_q <= 1'b0;
         dss_tx_en_q <= 1'b0;
      end else begin
         mpeg_rx_en_q <= mpeg_q[SFC_RX_ENABLE_BIT];
         mpeg_tx_en_q <= mpeg_q[SFC_TX_ENABLE_BIT];
         dss_rx_en_q <= dss_q[SFC_RX_ENABLE_BIT];
         dss_tx_en_q <= dss_q[SFC_TX_ENABLE_BIT];
      end
   end

   // aging enables of both paths
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_tx_age_q <= 1'b0;
         mpeg_rx_age_q <= 1'b0;
         dss_tx_age_q <= 1'b0;
         dss_rx_age_q <= 1'b0;
      end else begin
         mpeg_tx_age_q <= mpeg_q[SFC_TX_AGING_BIT];
         mpeg_rx_age_q <= mpeg_q[SFC_RX_AGING_BIT];
         dss_tx_age_q <= dss_q[SFC_TX_AGING_BIT];
         dss_rx_age_q <= dss_q[SFC_RX_AGING_BIT];
      end
   end

   // transmit packing class; every code is legal so no remap is needed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_class_q <= SFC_CLASS_DIV8;
         dss_class_q <= SFC_CLASS_DIV8;
      end else begin
         mpeg_class_q <= sfc_class_type'(mpeg_q[SFC_CLASS_MSB:SFC_CLASS_LSB]);
         dss_class_q <= sfc_class_type'(dss_q[SFC_CLASS_MSB:SFC_CLASS_LSB]);
      end
   end

   // receive header strip and timestamp width
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_hdr_strip_q <= 1'b0;
         mpeg_ext_ts_q <= 1'b0;
         dss_hdr_strip_q <= 1'b0;
         dss_ext_ts_q <= 1'b0;
      end else begin
         mpeg_hdr_strip_q <= mpeg_q[SFC_HDR_STRIP_BIT];
         mpeg_ext_ts_q <= mpeg_q[SFC_EXT_TS_BIT];
         dss_hdr_strip_q <= dss_q[SFC_HDR_STRIP_BIT];
         dss_ext_ts_q <= dss_q[SFC_EXT_TS_BIT];
      end
   end

   // 130-byte format readiness, only meaningful on the application port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_rx130_q <= 1'b0;
         mpeg_tx130_q <= 1'b0;
         dss_rx130_q <= 1'b0;
         dss_tx130_q <= 1'b0;
      end else begin
         mpeg_rx130_q <= mpeg_q[SFC_RX130_BIT];
         mpeg_tx130_q <= mpeg_q[SFC_TX130_BIT];
         dss_rx130_q <= dss_q[SFC_RX130_BIT];
         dss_tx130_q <= dss_q[SFC_TX130_BIT];
      end
   end

   // fifo data path: host or application port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_rx_port_q <= 1'b0;
         mpeg_tx_port_q <= 1'b0;
         dss_rx_port_q <= 1'b0;
         dss_tx_port_q <= 1'b0;
      end else begin
         mpeg_rx_port_q <= mpeg_q[SFC_RX_DEST_BIT];
         mpeg_tx_port_q <= mpeg_q[SFC_TX_SRC_BIT];
         dss_rx_port_q <= dss_q[SFC_RX_DEST_BIT];
         dss_tx_port_q <= dss_q[SFC_TX_SRC_BIT];
      end
   end

   // flush is a one-cycle pulse in the cycle after the write; never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_rx_flush_q <= 1'b0;
         mpeg_tx_flush_q <= 1'b0;
         dss_rx_flush_q <= 1'b0;
         dss_tx_flush_q <= 1'b0;
      end else begin
         mpeg_rx_flush_q <= wr_acc & hit_mpeg & pstrb[3] & pwdata[SFC_RX_FLUSH_BIT];
         mpeg_tx_flush_q <= wr_acc & hit_mpeg & pstrb[3] & pwdata[SFC_TX_FLUSH_BIT];
         dss_rx_flush_q <= wr_acc & hit_dss & pstrb[3] & pwdata[SFC_RX_FLUSH_BIT];
         dss_tx_flush_q <= wr_acc & hit_dss & pstrb[3] & pwdata[SFC_TX_FLUSH_BIT];
      end
   end

   // operating mode select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_mode_q <= 1'b0;
         dss_mode_q <= 1'b0;
      end else begin
         mpeg_mode_q <= mpeg_q[SFC_MODE_BIT];
         dss_mode_q <= dss_q[SFC_MODE_BIT];
      end
   end

   // automatic timestamp insertion on transmit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_ts_ins_q <= 1'b0;
         dss_ts_ins_q <= 1'b0;
      end else begin
         mpeg_ts_ins_q <= mpeg_q[SFC_TS_INSERT_BIT];
         dss_ts_ins_q <= dss_q[SFC_TS_INSERT_BIT];
      end
   end

   // alternate cell size; the sizes themselves live outside this block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_alt_cell_q <= 1'b0;
         dss_alt_cell_q <= 1'b0;
      end else begin
         mpeg_alt_cell_q <= mpeg_q[SFC_ALT_CELL_BIT];
         dss_alt_cell_q <= dss_q[SFC_ALT_CELL_BIT];
      end
   end

   // automatic header insertion on transmit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpeg_hdr_ins_q <= 1'b0;
         dss_hdr_ins_q <= 1'b0;
      end else begin
         mpeg_hdr_ins_q <= mpeg_q[SFC_HDR_INSERT_BIT];
         dss_hdr_ins_q <= dss_q[SFC_HDR_INSERT_BIT];
      end
   end

   // both formatters carry the same control layout
   always_comb begin
      mpeg_ctrl.rx_enable = mpeg_rx_en_q;
      mpeg_ctrl.tx_enable = mpeg_tx_en_q;
      mpeg_ctrl.tx_aging_enable = mpeg_tx_age_q;
      mpeg_ctrl.rx_aging_enable = mpeg_rx_age_q;
      mpeg_ctrl.tx_packing_class = mpeg_class_q;
      mpeg_ctrl.header_strip = mpeg_hdr_strip_q;
      mpeg_ctrl.extended_timestamp = mpeg_ext_ts_q;
      mpeg_ctrl.rx_format130_ready = mpeg_rx130_q;
      mpeg_ctrl.tx_format130_ready = mpeg_tx130_q;
      mpeg_ctrl.rx_to_port = mpeg_rx_port_q;
      mpeg_ctrl.tx_from_port = mpeg_tx_port_q;
      mpeg_ctrl.rx_fifo_flush = mpeg_rx_flush_q;
      mpeg_ctrl.tx_fifo_flush = mpeg_tx_flush_q;
      mpeg_ctrl.stream_mode_select = mpeg_mode_q;
      mpeg_ctrl.tx_timestamp_insert = mpeg_ts_ins_q;
      mpeg_ctrl.alternate_cell_size_enable = mpeg_alt_cell_q;
      mpeg_ctrl.tx_header_insert = mpeg_hdr_ins_q;
      dss_ctrl.rx_enable = dss_rx_en_q;
      dss_ctrl.tx_enable = dss_tx_en_q;
      dss_ctrl.tx_aging_enable = dss_tx_age_q;
      dss_ctrl.rx_aging_enable = dss_rx_age_q;
      dss_ctrl.tx_packing_class = dss_class_q;
      dss_ctrl.header_strip = dss_hdr_strip_q;
      dss_ctrl.extended_timestamp = dss_ext_ts_q;
      dss_ctrl.rx_format130_ready = dss_rx130_q;
      dss_ctrl.tx_format130_ready = dss_tx130_q;
      dss_ctrl.rx_to_port = dss_rx_port_q;
      dss_ctrl.tx_from_port = dss_tx_port_q;
      dss_ctrl.rx_fifo_flush = dss_rx_flush_q;
      dss_ctrl.tx_fifo_flush = dss_tx_flush_q;
      dss_ctrl.stream_mode_select = dss_mode_q;
      dss_ctrl.tx_timestamp_insert = dss_ts_ins_q;
      dss_ctrl.alternate_cell_size_enable = dss_alt_cell_q;
      dss_ctrl.tx_header_insert = dss_hdr_ins_q;
   end

   // read path: flush bits are masked out of storage so they read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= psel & ~penable & ~(hit_mpeg | hit_dss);
         if (psel & ~penable & ~pwrite) begin
            if (hit_mpeg) begin
               prdata_q <= mpeg_q;
            end else if (hit_dss) begin
               prdata_q <= dss_q;
            end else begin
               prdata_q <= '0;
            end
         end else if (rd_acc) begin
            prdata_q <= prdata_q;
         end else begin
            prdata_q <= '0;
         end
      end
   end

   // pins cross two flip-flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txerr_sync_q <= '0;
         rxstat_sync_q <= '0;
      end else begin
         txerr_sync_q <= {txerr_sync_q[0], port_tx_error_in};
         rxstat_sync_q <= {rxstat_sync_q[0], rx_status_bit};
      end
   end

   // error mapping follows the formatter currently selected by the mode bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_err_q <= 1'b0;
         rx_err_q <= 1'b0;
      end else begin
         if (mpeg_q[SFC_MODE_BIT] ? mpeg_q[SFC_TX_ERR_MODE_BIT] : dss_q[SFC_TX_ERR_MODE_BIT]) begin
            tx_err_q <= txerr_sync_q[1];
         end else begin
            tx_err_q <= 1'b0;
         end
         if (mpeg_q[SFC_MODE_BIT] ? mpeg_q[SFC_RX_ERR_MODE_BIT] : dss_q[SFC_RX_ERR_MODE_BIT]) begin
            rx_err_q <= rxstat_sync_q[1];
         end else begin
            rx_err_q <= 1'b0;
         end
      end
   end

   // pready always high: zero wait states keeps the host path simple
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign tx_error_status_bit = tx_err_q;
   assign port_rx_error_out = rx_err_q;
endmodule : sfc_regs
`default_nettype wire

//--- verification/sfc_app_port.sv
// application port model raising its error pins on request
`timescale 1ns/1ps
`default_nettype none
module sfc_app_port
   import sfc_pkg::*;
(
   // clock and request
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] err_req,
   // error pins
   output logic port_tx_error_in,
   output logic rx_status_bit
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_tx_error_in <= 1'b0;
         rx_status_bit <= 1'b0;
      end else begin
         port_tx_error_in <= err_req[1];
         rx_status_bit <= err_req[0];
      end
   end
endmodule : sfc_app_port
`default_nettype wire

//--- verification/sfc_regs_sva.sv
// assertions on the ports of the stream formatter control registers
`timescale 1ns/1ps
`default_nettype none
module sfc_regs_chk
   import sfc_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // controls and error pins
   input wire sfc_ctrl_type mpeg_ctrl,
   input wire sfc_ctrl_type dss_ctrl,
   input wire logic port_tx_error_in,
   input wire logic rx_status_bit,
   input wire logic tx_error_status_bit,
   input wire logic port_rx_error_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   wire logic wm = acc && pwrite && paddr == SFC_MPEG_CTRL_ADDR;
   wire logic wd = acc && pwrite && paddr == SFC_DSS_CTRL_ADDR;
   wire logic map = paddr == SFC_MPEG_CTRL_ADDR || paddr == SFC_DSS_CTRL_ADDR;
   chk_rx_flush_pulse: assert property (wm && pstrb[3] && pwdata[26] |=>
      mpeg_ctrl.rx_fifo_flush ##1 !mpeg_ctrl.rx_fifo_flush) else $error("rx flush pulse wrong");
   chk_dss_tx_flush: assert property (wd && pstrb[3] && pwdata[27] |=>
      dss_ctrl.tx_fifo_flush ##1 !dss_ctrl.tx_fifo_flush) else $error("dss tx flush pulse wrong");
   chk_mode_follows: assert property (wm && pstrb[3] |-> ##2
      mpeg_ctrl.stream_mode_select == $past(pwdata[28], 2)) else $error("mode bit not applied");
   chk_class_follows: assert property (wd && pstrb[1] |-> ##2
      dss_ctrl.tx_packing_class == $past(pwdata[15:13], 2)) else $error("class not applied");
   chk_reserved_zero: assert property (acc && !pwrite |-> (prdata & ~SFC_RW_MASK) == 32'h0)
      else $error("reserved or flush bit read nonzero");
   chk_unmapped_err: assert property (acc && !map |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_rx_err_map: assert property (port_rx_error_out |-> $past(rx_status_bit, 3))
      else $error("rx error out without status");
   chk_tx_err_map: assert property (tx_error_status_bit |-> $past(port_tx_error_in, 3))
      else $error("tx error status without pin");
   cover property (wm && pwdata[26]);
   cover property (acc && !map);
   cover property (port_rx_error_out && tx_error_status_bit);
endmodule : sfc_regs_chk
bind sfc_regs sfc_regs_chk i_sfc_regs_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .prdata, .pready, .pslverr, .mpeg_ctrl, .dss_ctrl, .port_tx_error_in, .rx_status_bit,
   .tx_error_status_bit, .port_rx_error_out);
`default_nettype wire

//--- verification/test_stream_formatter_control.sv
// self-checking bench for the stream formatter control registers
`timescale 1ns/1ps
`default_nettype none
module test_stream_formatter_control;
   import sfc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic port_tx_error_in, rx_status_bit, tx_error_status_bit, port_rx_error_out;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [1:0] err_req;
   sfc_ctrl_type mpeg_ctrl, dss_ctrl, x;
   int mismatches = 0;
   int checked = 0;
   sfc_regs i_sfc_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .mpeg_ctrl, .dss_ctrl, .port_tx_error_in, .rx_status_bit, .tx_error_status_bit,
      .port_rx_error_out);
   sfc_app_port i_sfc_app_port (.pclk, .presetn, .err_req, .port_tx_error_in, .rx_status_bit);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task results;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // one apb transfer; read data and error taken at the edge pready is seen
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task t_layout(input logic [7:0] a);
      xfer(1'b1, a, 32'hffff_ffff, 4'hf);
      xfer(1'b0, a, 32'h0, 4'h0);
      cmp(q, SFC_RW_MASK);
      x = '1;
      x.rx_fifo_flush = 1'b0;
      x.tx_fifo_flush = 1'b0;
      cmp(32'(a == SFC_MPEG_CTRL_ADDR ? mpeg_ctrl : dss_ctrl), 32'(x));
      xfer(1'b1, a, 32'h0, 4'hf);
      repeat (2) @(posedge pclk);
      cmp(32'(a == SFC_MPEG_CTRL_ADDR ? mpeg_ctrl : dss_ctrl), 32'h0);
   endtask : t_layout
   task t_class;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, SFC_DSS_CTRL_ADDR, 32'(i) << 13, 4'h2);
         xfer(1'b0, SFC_DSS_CTRL_ADDR, 32'h0, 4'h0);
         cmp(q, 32'(i) << 13);
         cmp(32'(dss_ctrl.tx_packing_class), 32'(i));
      end
   endtask : t_class
   task t_flush;
      xfer(1'b1, SFC_MPEG_CTRL_ADDR, 32'h0c00_0000, 4'hf);
      @(posedge pclk);
      cmp({mpeg_ctrl.rx_fifo_flush, mpeg_ctrl.tx_fifo_flush}, 32'h3);
      @(posedge pclk);
      cmp({mpeg_ctrl.rx_fifo_flush, mpeg_ctrl.tx_fifo_flush}, 32'h0);
      xfer(1'b0, SFC_MPEG_CTRL_ADDR, 32'h0, 4'h0);
      cmp(q, 32'h0);
   endtask : t_flush
   task t_unmapped;
      xfer(1'b1, 8'hf8, 32'hffff_ffff, 4'hf);
      cmp(e, 1'b1);
      xfer(1'b0, 8'hf8, 32'h0, 4'h0);
      cmp({31'h0, e}, 32'h1);
      cmp(q, 32'h0);
   endtask : t_unmapped
   task t_errmap(input logic [31:0] v, input logic [31:0] exp);
      xfer(1'b1, SFC_DSS_CTRL_ADDR, v, 4'hf);
      repeat (6) @(posedge pclk);
      cmp({30'h0, tx_error_status_bit, port_rx_error_out}, exp);
   endtask : t_errmap
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb, err_req} = '0;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, SFC_MPEG_CTRL_ADDR, 32'h0, 4'h0);
      cmp(q, SFC_CTRL_RESET);
      xfer(1'b0, SFC_DSS_CTRL_ADDR, 32'h0, 4'h0);
      cmp(q, 32'h0);
      t_layout(SFC_MPEG_CTRL_ADDR);
      t_layout(SFC_DSS_CTRL_ADDR);
      t_class();
      t_flush();
      t_unmapped();
      err_req <= 2'b11;
      t_errmap(32'h30, 32'h3);
      t_errmap(32'h0, 32'h0);
      err_req <= 2'b00;
      t_errmap(32'h30, 32'h0);
      results();
   end
   initial begin
      #100000;
      mismatches++;
      results();
   end
endmodule : test_stream_formatter_control
`default_nettype wire
